//--- src/rgbpt_pkg.sv
// Purpose: shared constants for the rgb panel timing link (source and panel ends)
// Assumes: 125 MHz system clock on both ends
// Notes:   all horizontal counts are in pixel clocks, vertical counts in lines
package rgbpt_pkg;
   // system clock and pixel clock divider
   localparam int CLK_MHZ       = 125;
   localparam int PIX_DIV       = 4;    // 125 MHz / 4 = 31.25 MHz pixel clock
   // panel reset pulse
   localparam int RST_PULSE_US  = 10;
   localparam int RST_CYC       = RST_PULSE_US * CLK_MHZ;
   // horizontal timing, counted from the start of horizontal sync
   localparam int H_ACTIVE      = 800;
   localparam int H_BACK        = 46;
   localparam int H_SYNC        = 20;
   localparam int H_FRONT       = 210;
   // vertical timing, counted from the start of vertical sync
   localparam int V_ACTIVE      = 600;
   localparam int V_BACK        = 23;
   localparam int V_SYNC        = 3;
   localparam int V_FRONT       = 12;
   // counter widths and buffering
   localparam int H_CNT_W       = 11;
   localparam int V_CNT_W       = 10;
   localparam int RST_CNT_W     = 11;
   localparam int RGB_W         = 24;
   localparam int FIFO_DEPTH    = 4;
   // dither step: add a 2x2 ordered offset, saturate, then ground the two lsbs
   function automatic logic [7:0] rgbpt_dither(input logic [7:0] c, input logic [1:0] ofs);
      logic [8:0] sum;
      sum = {1'b0, c} + {7'h00, ofs};
      if (sum[8])
         sum = 9'h0ff;
      return {sum[7:2], 2'h0};
   endfunction : rgbpt_dither
endpackage : rgbpt_pkg

//--- src/rgbpt_if.sv
// Purpose: parallel rgb panel link between timing source and panel
// Assumes: source drives every signal, panel only listens
// Notes:   pixel clock is a plain wire here; the panel oversamples it
`timescale 1ns/10ps
interface rgbpt_if;
   logic        pixelClock;
   logic        hSync;
   logic        vSync;
   logic        pixelValid;
   logic [23:0] rgb;
   logic        panelRstN;
   logic        modeSelect;
   logic        ditherDisable;
   logic        verticalFlip;
   logic        horizontalFlip;
   modport source (output pixelClock, hSync, vSync, pixelValid, rgb, panelRstN,
                   modeSelect, ditherDisable, verticalFlip, horizontalFlip);
   modport panel  (input  pixelClock, hSync, vSync, pixelValid, rgb, panelRstN,
                   modeSelect, ditherDisable, verticalFlip, horizontalFlip);
endinterface : rgbpt_if

//--- src/rgbpt_source.sv
// Purpose: display controller end: makes pixel clock, syncs, valid strobe and pixel data
// Assumes: user pushes pixels in raster order through a small fifo
// Notes:   all link timing comes from parameters; pixel clock is a clk divider
// Overview of operation
// [R1] each active line carries 800 pixels
// [R2] pixel clock at most 50 MHz
// [R3] pixel clock duty between 40 and 60 percent
// [R4] line period 862 to 1200 clocks
// [R5] horizontal sync 1 to 40 clocks
// [R6] back porch fixed at 46 clocks
// [R7] front porch 16 to 354 clocks
// [R8] each frame carries 600 active lines
// [R9] frame period 624 to 700 lines
// [R10] vertical sync 1 to 20 lines
// [R11] vertical back porch fixed at 23 lines
// [R12] vertical front porch 1 to 77 lines
// [R13] panel reset held low at least 10 us
// [R14] drive link only after supplies, before backlight; pixel clock here starts in the same cycle as backlight
// [R15] mode high: valid strobe; low: syncs only
// [R16] panel in reset while reset input low
// [R17] dither disable: 18-bit, else dither 24-bit
// [R18] two flip inputs select scan order
// [R19] valid strobe only on active pixels
// [R20] link changes away from sampling edge
`timescale 1ns/10ps

// fifo with registered ready, drained by the timing generator
module rgbpt_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // fill side
   input  wire logic             inValid,
   output      logic             inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output      logic             outValid,
   input  wire logic             outReady,
   output      logic [WIDTH-1:0] outData
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wrPtr;
      logic [PTR_W-1:0]            rdPtr;
      logic [PTR_W:0]              count;
      logic                        ready;
   } rgbpt_fifo_state_type;
   rgbpt_fifo_state_type fifo_reg, fifo_next;
   logic                 doWr;
   logic                 doRd;

   // pointer and count update; ready is registered so it never depends on outReady
   always_comb
   begin
      fifo_next = fifo_reg;
      doWr      = inValid && fifo_reg.ready;
      doRd      = outReady && (fifo_reg.count != '0);
      if (doWr)
      begin
         fifo_next.mem[fifo_reg.wrPtr] = inData;
         fifo_next.wrPtr = (fifo_reg.wrPtr == PTR_W'(DEPTH - 1)) ? '0 : fifo_reg.wrPtr + 1'b1;
      end
      if (doRd)
         fifo_next.rdPtr = (fifo_reg.rdPtr == PTR_W'(DEPTH - 1)) ? '0 : fifo_reg.rdPtr + 1'b1;
      fifo_next.count = fifo_reg.count + (PTR_W + 1)'(doWr) - (PTR_W + 1)'(doRd);
      fifo_next.ready = fifo_next.count < (PTR_W + 1)'(DEPTH);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         fifo_reg <= '0;
      else if (ce)
         fifo_reg <= fifo_next;
   end

   assign inReady  = fifo_reg.ready;
   assign outValid = fifo_reg.count != '0;
   assign outData  = fifo_reg.mem[fifo_reg.rdPtr];
endmodule : rgbpt_fifo

module rgbpt_source
   import rgbpt_pkg::*;
#(
   parameter int HSYNC_W  = H_SYNC,
   parameter int HBACK    = H_BACK,
   parameter int HACT     = H_ACTIVE,
   parameter int HFRONT   = H_FRONT,
   parameter int VSYNC_W  = V_SYNC,
   parameter int VBACK    = V_BACK,
   parameter int VACT     = V_ACTIVE,
   parameter int VFRONT   = V_FRONT,
   parameter int RST_HOLD = RST_CYC
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   // panel link
   rgbpt_if.source               link,
   // user pixel stream
   input  wire logic             pixInValid,
   output      logic             pixInReady,
   input  wire logic [RGB_W-1:0] pixInData,
   // user control
   input  wire logic             supplyGood,
   input  wire logic             modeSel,
   input  wire logic             ditherOff,
   input  wire logic             flipV,
   input  wire logic             flipH,
   // status
   output      logic             backlightEn,
   output      logic             underrun
);
   localparam int HTOTAL = HBACK + HACT + HFRONT;
   localparam int VTOTAL = VBACK + VACT + VFRONT;
   localparam int HALF   = PIX_DIV / 2;

   typedef struct packed {
      logic [1:0]           div;
      logic [H_CNT_W-1:0]   hCnt;
      logic [V_CNT_W-1:0]   vCnt;
      logic [RST_CNT_W-1:0] rstCnt;
      logic                 running;
      logic                 pixClk;
      logic                 hs;
      logic                 vs;
      logic                 de;
      logic [RGB_W-1:0]     rgb;
      logic                 rstN;
      logic                 mode;
      logic                 dith;
      logic                 vf;
      logic                 hf;
      logic                 bl;
      logic                 under;
   } rgbpt_src_state_type;
   rgbpt_src_state_type src_reg, src_next;

   logic             fifoValid;
   logic             fifoPop;
   logic [RGB_W-1:0] fifoData;
   logic             act;

   rgbpt_fifo #(
      .WIDTH (RGB_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .inValid  (pixInValid),
      .inReady  (pixInReady),
      .inData   (pixInData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // reset sequencing, pixel clock divider and raster counters
   always_comb
   begin
      src_next       = src_reg;
      src_next.under = 1'b0;
      fifoPop        = 1'b0;
      act            = 1'b0;
      if (!src_reg.running)
      begin
         // [R14] quiet link until supplies
         src_next.rstN = 1'b0;
         if (supplyGood)
            src_next.rstCnt = src_reg.rstCnt + 1'b1;
         else
            src_next.rstCnt = '0;
         // [R13] reset low 10 us
         if (supplyGood && src_reg.rstCnt == RST_CNT_W'(RST_HOLD - 1))
         begin
            src_next.rstN    = 1'b1;
            src_next.running = 1'b1;
            // wrap to zero on the next tick, so the first high phase is full width
            src_next.div     = 2'(PIX_DIV - 1);
            src_next.hCnt    = H_CNT_W'(HTOTAL - 1);
            src_next.vCnt    = V_CNT_W'(VTOTAL - 1);
         end
      end
      else
      begin
         // [R2] [R3] divide by four, even duty
         src_next.div    = (src_reg.div == 2'(PIX_DIV - 1)) ? 2'h0 : src_reg.div + 2'h1;
         src_next.pixClk = src_next.div < 2'(HALF);
         src_next.mode   = modeSel;
         src_next.dith   = ditherOff;
         src_next.vf     = flipV;
         src_next.hf     = flipH;
         // [R14] backlight on in the same cycle as the first pixel clock high, before any sync or data
         src_next.bl     = 1'b1;
         // [R20] update on falling edge
         if (src_next.div == 2'(HALF))
         begin
            // [R4] [R9] line and frame wrap
            if (src_reg.hCnt == H_CNT_W'(HTOTAL - 1))
            begin
               src_next.hCnt = '0;
               src_next.vCnt = (src_reg.vCnt == V_CNT_W'(VTOTAL - 1)) ? '0 : src_reg.vCnt + 1'b1;
            end
            else
               src_next.hCnt = src_reg.hCnt + 1'b1;
            // [R5] [R10] sync widths
            src_next.hs = src_next.hCnt < H_CNT_W'(HSYNC_W);
            src_next.vs = src_next.vCnt < V_CNT_W'(VSYNC_W);
            // [R1] [R6] [R7] [R8] [R11] [R12] active window
            act = (src_next.hCnt >= H_CNT_W'(HBACK)) && (src_next.hCnt < H_CNT_W'(HBACK + HACT))
               && (src_next.vCnt >= V_CNT_W'(VBACK)) && (src_next.vCnt < V_CNT_W'(VBACK + VACT));
            // [R15] [R19] strobe in valid mode only
            src_next.de = act && modeSel;
            fifoPop     = act;
            if (act && fifoValid)
               src_next.rgb = fifoData;
            else
               src_next.rgb = '0;            // blanking and starved pixels go black
            src_next.under = act && !fifoValid;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         src_reg <= '0;
      else if (ce)
         src_reg <= src_next;
   end

   // link and status straight from the state register
   assign link.pixelClock     = src_reg.pixClk;
   assign link.hSync          = src_reg.hs;
   assign link.vSync          = src_reg.vs;
   assign link.pixelValid     = src_reg.de;
   assign link.rgb            = src_reg.rgb;
   assign link.panelRstN      = src_reg.rstN;
   assign link.modeSelect     = src_reg.mode;
   assign link.ditherDisable  = src_reg.dith;
   assign link.verticalFlip   = src_reg.vf;
   assign link.horizontalFlip = src_reg.hf;
   assign backlightEn         = src_reg.bl;
   assign underrun            = src_reg.under;
endmodule : rgbpt_source

//--- src/rgbpt_panel.sv
// Purpose: panel end: oversamples the link, recovers pixel position and colour
// Assumes: link comes from another clock domain; pixel clock well below clk / 2
// Notes:   every link signal passes two flip-flops before any logic looks at it
`timescale 1ns/10ps
module rgbpt_panel
   import rgbpt_pkg::*;
#(
   parameter int HBACK = H_BACK,
   parameter int HACT  = H_ACTIVE,
   parameter int VBACK = V_BACK,
   parameter int VACT  = V_ACTIVE
) (
   // clock, reset, enable
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               ce,
   // panel link
   rgbpt_if.panel                  link,
   // recovered pixels
   output      logic               pixOutValid,
   output      logic [V_CNT_W-1:0] pixX,
   output      logic [V_CNT_W-1:0] pixY,
   output      logic [RGB_W-1:0]   pixRgb,
   // status
   output      logic               inReset,
   output      logic               lineLenErr
);
   localparam int LW = RGB_W + 9;

   typedef struct packed {
      logic [LW-1:0]      sync1;
      logic [LW-1:0]      sync2;
      logic               prevClk;
      logic               prevHs;
      logic               prevVs;
      logic               prevDe;
      logic [H_CNT_W-1:0] hCnt;
      logic [V_CNT_W-1:0] vLine;
      logic [V_CNT_W-1:0] xCnt;
      logic [V_CNT_W-1:0] yCnt;
      logic               oValid;
      logic [V_CNT_W-1:0] oX;
      logic [V_CNT_W-1:0] oY;
      logic [RGB_W-1:0]   oRgb;
      logic               rst;
      logic               err;
   } rgbpt_pan_state_type;
   rgbpt_pan_state_type pan_reg, pan_next;

   logic               sClk, sHs, sVs, sDe, sRstN, sMode, sDith, sVf, sHf;
   logic [RGB_W-1:0]   sRgb;
   logic               act;
   logic [V_CNT_W-1:0] px;
   logic [V_CNT_W-1:0] py;
   logic [1:0]         ofs;

   // second synchroniser stage fields
   assign {sClk, sHs, sVs, sDe, sRstN, sMode, sDith, sVf, sHf, sRgb} = pan_reg.sync2;

   // sample on rising pixel clock, then place the pixel
   always_comb
   begin
      pan_next        = pan_reg;
      pan_next.sync1  = {link.pixelClock, link.hSync, link.vSync, link.pixelValid,
                         link.panelRstN, link.modeSelect, link.ditherDisable,
                         link.verticalFlip, link.horizontalFlip, link.rgb};
      pan_next.sync2  = pan_reg.sync1;
      pan_next.prevClk = sClk;
      pan_next.oValid = 1'b0;
      pan_next.err    = 1'b0;
      act = 1'b0;
      px  = '0;
      py  = '0;
      ofs = '0;
      // [R16] hold reset state
      pan_next.rst = !sRstN;
      if (!sRstN)
      begin
         pan_next.hCnt   = '0;
         pan_next.vLine  = '0;
         pan_next.xCnt   = '0;
         pan_next.yCnt   = '0;
         pan_next.prevHs = 1'b0;
         pan_next.prevVs = 1'b0;
         pan_next.prevDe = 1'b0;
      end
      // [R20] sample on rising edge
      else if (sClk && !pan_reg.prevClk)
      begin
         pan_next.prevHs = sHs;
         pan_next.prevVs = sVs;
         pan_next.prevDe = sDe;
         // sync-mode position from the sync edges
         pan_next.hCnt = (sHs && !pan_reg.prevHs) ? '0 : pan_reg.hCnt + 1'b1;
         if (sVs && !pan_reg.prevVs)
            pan_next.vLine = '0;
         else if (sHs && !pan_reg.prevHs)
            pan_next.vLine = pan_reg.vLine + 1'b1;
         // [R15] choose framing mode
         if (sMode)
         begin
            act = sDe;
            px  = pan_reg.xCnt;
            py  = pan_reg.yCnt;
            if (sDe)
               pan_next.xCnt = pan_reg.xCnt + 1'b1;
            // [R1] [R8] line length and count
            if (!sDe && pan_reg.prevDe)
            begin
               pan_next.err  = pan_reg.xCnt != V_CNT_W'(HACT);
               pan_next.xCnt = '0;
               pan_next.yCnt = (pan_reg.yCnt == V_CNT_W'(VACT - 1)) ? '0 : pan_reg.yCnt + 1'b1;
            end
            if (sVs && !pan_reg.prevVs)
               pan_next.yCnt = '0;
         end
         else
         begin
            // [R6] [R11] fixed back porches
            act = (pan_next.hCnt >= H_CNT_W'(HBACK)) && (pan_next.hCnt < H_CNT_W'(HBACK + HACT))
               && (pan_next.vLine >= V_CNT_W'(VBACK))
               && (pan_next.vLine < V_CNT_W'(VBACK + VACT));
            px  = V_CNT_W'(pan_next.hCnt - H_CNT_W'(HBACK));
            py  = pan_next.vLine - V_CNT_W'(VBACK);
         end
         if (act)
         begin
            pan_next.oValid = 1'b1;
            // [R18] scan order from flips
            pan_next.oX = sHf ? px : V_CNT_W'(HACT - 1) - px;
            pan_next.oY = sVf ? V_CNT_W'(VACT - 1) - py : py;
            // [R17] dither or ground lsbs
            ofs = {px[0] ^ py[0], py[0]};
            if (sDith)
               pan_next.oRgb = sRgb & 24'hfcfcfc;
            else
               pan_next.oRgb = {rgbpt_dither(sRgb[23:16], ofs), rgbpt_dither(sRgb[15:8], ofs),
                                rgbpt_dither(sRgb[7:0], ofs)};
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pan_reg <= '0;
      else if (ce)
         pan_reg <= pan_next;
   end

   assign pixOutValid = pan_reg.oValid;
   assign pixX        = pan_reg.oX;
   assign pixY        = pan_reg.oY;
   assign pixRgb      = pan_reg.oRgb;
   assign inReset     = pan_reg.rst;
   assign lineLenErr  = pan_reg.err;
endmodule : rgbpt_panel

//--- test/rgbpt_chk.sv
// Purpose: timing checker watching the rgb panel link wires
// Assumes: link sampled on clk; one pixel clock spans PIX_DIV clk cycles
// Notes:   horizontal run lengths are counted in clk cycles, so their limits scale by PIX_DIV
`timescale 1ns/10ps
module rgbpt_chk
   import rgbpt_pkg::*;
#(
   parameter int HSYNC_W  = H_SYNC,
   parameter int HBACK    = H_BACK,
   parameter int HACT     = H_ACTIVE,
   parameter int HFRONT   = H_FRONT,
   parameter int VSYNC_W  = V_SYNC,
   parameter int VBACK    = V_BACK,
   parameter int VACT     = V_ACTIVE,
   parameter int VFRONT   = V_FRONT,
   parameter int RST_HOLD = RST_CYC
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // link
   input wire logic        pixelClock,
   input wire logic        hSync,
   input wire logic        vSync,
   input wire logic        pixelValid,
   input wire logic [23:0] rgb,
   input wire logic        panelRstN,
   input wire logic        modeSelect
);
   localparam int LINE_CYC = (HBACK + HACT + HFRONT) * PIX_DIV;
   localparam int FRAME_L  = VBACK + VACT + VFRONT - 1;
   logic [15:0] hsLen_reg;
   logic [15:0] deLen_reg;
   logic [15:0] sinceHs_reg;
   logic [15:0] rstLow_reg;
   logic [9:0]  vsLines_reg;
   logic [9:0]  lineCnt_reg;
   logic [9:0]  actLines_reg;
   logic        hsOld_reg;
   logic        vsOld_reg;
   logic        deOld_reg;
   logic        frame_reg;
   logic        hsRise;
   logic        vsRise;
   assign hsRise = hSync & ~hsOld_reg;
   assign vsRise = vSync & ~vsOld_reg;
   // run lengths; sinceHs stays 0 until a first line start so no partial line is judged
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {hsOld_reg, vsOld_reg, deOld_reg, frame_reg} <= 4'h0;
         {hsLen_reg, deLen_reg, sinceHs_reg, rstLow_reg} <= 64'h0;
         {vsLines_reg, lineCnt_reg, actLines_reg} <= 30'h0;
      end
      else
      begin
         hsOld_reg <= hSync;
         vsOld_reg <= vSync;
         deOld_reg <= pixelValid;
         frame_reg <= frame_reg | vsRise;
         hsLen_reg <= hSync ? hsLen_reg + 16'h1 : 16'h0;
         deLen_reg <= pixelValid ? deLen_reg + 16'h1 : 16'h0;
         sinceHs_reg <= hsRise ? 16'h1 : sinceHs_reg + {15'h0, sinceHs_reg != 16'h0};
         rstLow_reg <= panelRstN ? 16'h0 : rstLow_reg + {15'h0, rstLow_reg != 16'hffff};
         vsLines_reg <= vsRise ? 10'h1 : vsLines_reg + {9'h0, hsRise & vSync};
         lineCnt_reg <= vsRise ? 10'h0 : lineCnt_reg + {9'h0, hsRise};
         actLines_reg <= vsRise ? 10'h0 : actLines_reg + {9'h0, deOld_reg & ~pixelValid};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // two cycles high then two low
   sequence pixPeriod_s;
      pixelClock ##1 !pixelClock [*2] ##1 pixelClock;
   endsequence
   chk_clock_duty: assert property ($rose(pixelClock) |=> pixPeriod_s)
      else $error("pixel clock period or duty wrong");
   chk_data_edge: assert property (
      !$stable({hSync, vSync, pixelValid, rgb}) |-> $fell(pixelClock))
      else $error("link changed away from falling pixel clock");
   chk_hsync_width: assert property ($fell(hSync) |-> hsLen_reg == HSYNC_W * PIX_DIV)
      else $error("horizontal sync width wrong");
   chk_active_len: assert property (
      $fell(pixelValid) |-> deLen_reg == HACT * PIX_DIV)
      else $error("valid run length wrong");
   chk_back_porch: assert property (
      $rose(pixelValid) |-> sinceHs_reg == HBACK * PIX_DIV)
      else $error("horizontal back porch wrong");
   chk_line_period: assert property (
      $rose(hSync) && sinceHs_reg != 16'h0 |-> sinceHs_reg == LINE_CYC)
      else $error("line period wrong");
   chk_vsync_width: assert property ($fell(vSync) |-> vsLines_reg == VSYNC_W)
      else $error("vertical sync width wrong");
   chk_vert_porch: assert property (
      $rose(pixelValid) |-> lineCnt_reg == VBACK + actLines_reg)
      else $error("active line out of place");
   chk_frame_shape: assert property (
      $rose(vSync) && frame_reg |->
      lineCnt_reg == FRAME_L && (!modeSelect || actLines_reg == VACT))
      else $error("frame line count wrong");
   chk_reset_hold: assert property ($rose(panelRstN) |-> rstLow_reg >= RST_HOLD)
      else $error("panel reset pulse too short");
   chk_quiet_reset: assert property (
      !panelRstN |-> !(pixelClock | hSync | vSync | pixelValid))
      else $error("link driven while panel held in reset");
   chk_mode_strobe: assert property (!modeSelect |-> !pixelValid)
      else $error("valid strobe in sync framing");
endmodule : rgbpt_chk

//--- test/testbench.sv
// Purpose: self-checking bench joining source and panel over one link
// Assumes: shrunk timing, so one frame lasts a few hundred clk cycles
// Notes:   the last frame runs starved, which only works once, so it ends the run
`timescale 1ns/10ps
module testbench;
   import rgbpt_pkg::*;
   // shrunk timing shared by both ends and the checker
   localparam int HS = 2;
   localparam int HB = 5;
   localparam int HA = 8;
   localparam int HF = 3;
   localparam int VS = 1;
   localparam int VB = 2;
   localparam int VA = 4;
   localparam int VF = 1;
   localparam int RH = 8;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        ce = 1'b1;
   logic        pixInValid = 1'b0;
   logic        pixInReady;
   logic [23:0] pixInData = 24'h0;
   logic        supplyGood = 1'b0;
   logic        modeSel = 1'b1;
   logic        ditherOff = 1'b1;
   logic        flipV = 1'b0;
   logic        flipH = 1'b1;
   logic        backlightEn;
   logic        underrun;
   logic        pixOutValid;
   logic [9:0]  pixX;
   logic [9:0]  pixY;
   logic [23:0] pixRgb;
   logic        inReset;
   logic        lineLenErr;
   logic        feedOn = 1'b0;
   logic        underSeen = 1'b0;
   logic        lenErrSeen = 1'b0;
   logic [23:0] expWord;
   logic [23:0] q[$];
   int          err_count = 0;
   int          tests_run = 0;
   int          ex = 0;
   int          ey = 0;
   int          n;
   always #4 clk = ~clk;
   rgbpt_if rgbpt_if_i ();
   rgbpt_source #(.HSYNC_W(HS), .HBACK(HB), .HACT(HA), .HFRONT(HF), .VSYNC_W(VS),
      .VBACK(VB), .VACT(VA), .VFRONT(VF), .RST_HOLD(RH)) rgbpt_source_i (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .link(rgbpt_if_i.source),
      .pixInValid(pixInValid), .pixInReady(pixInReady), .pixInData(pixInData),
      .supplyGood(supplyGood), .modeSel(modeSel), .ditherOff(ditherOff), .flipV(flipV),
      .flipH(flipH), .backlightEn(backlightEn), .underrun(underrun));
   rgbpt_panel #(.HBACK(HB), .HACT(HA), .VBACK(VB), .VACT(VA)) rgbpt_panel_i (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .link(rgbpt_if_i.panel),
      .pixOutValid(pixOutValid), .pixX(pixX), .pixY(pixY), .pixRgb(pixRgb),
      .inReset(inReset), .lineLenErr(lineLenErr));
   rgbpt_chk #(.HSYNC_W(HS), .HBACK(HB), .HACT(HA), .HFRONT(HF), .VSYNC_W(VS),
      .VBACK(VB), .VACT(VA), .VFRONT(VF), .RST_HOLD(RH)) rgbpt_chk_i (
      .clk(clk), .sys_rst(sys_rst), .pixelClock(rgbpt_if_i.pixelClock),
      .hSync(rgbpt_if_i.hSync), .vSync(rgbpt_if_i.vSync),
      .pixelValid(rgbpt_if_i.pixelValid), .rgb(rgbpt_if_i.rgb),
      .panelRstN(rgbpt_if_i.panelRstN), .modeSelect(rgbpt_if_i.modeSelect));
   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   // bounded wait for a vertical sync level
   task automatic waitVs(input logic lvl);
      int k;
      for (k = 0; k < 2000 && rgbpt_if_i.vSync !== lvl; k++)
         @(posedge clk);
      if (k == 2000)
      begin
         err_count++;
         summarize();
      end
   endtask : waitVs
   // colour model: ordered offset, saturate, two lsbs dropped
   function automatic logic [23:0] expRgb(input logic [23:0] c, input int x, input int y,
                                          input logic off);
      logic [23:0] r;
      int          s;
      for (int k = 0; k < 3; k++)
      begin
         s = int'(c[k*8 +: 8]) + (off ? 0 : 2 * ((x ^ y) & 1) + (y & 1));
         r[k*8 +: 8] = (s > 255) ? 8'hfc : {s[7:2], 2'h0};
      end
      return r;
   endfunction : expRgb
   // push stream; near-white words hit the saturation corner
   always @(posedge clk)
   begin
      pixInValid <= feedOn;
      if (pixInValid && pixInReady === 1'b1)
      begin
         q.push_back(pixInData);
         pixInData <= ($urandom % 4 == 0) ? 24'hfdfeff : 24'($urandom);
      end
   end
   // every recovered pixel against the raster model; empty queue means underrun black
   always @(posedge clk)
   begin
      if (underrun === 1'b1)
         underSeen <= 1'b1;
      if (!sys_rst && lineLenErr !== 1'b0)
         lenErrSeen <= 1'b1;
      if (pixOutValid === 1'b1)
      begin
         expWord = (q.size() > 0) ? q.pop_front() : 24'h0;
         check("pixX", pixX, flipH ? ex : HA - 1 - ex);
         check("pixY", pixY, flipV ? VA - 1 - ey : ey);
         check("pixRgb", pixRgb, expRgb(expWord, ex, ey, ditherOff));
         ex = (ex == HA - 1) ? 0 : ex + 1;
         ey = (ex != 0) ? ey : ((ey == VA - 1) ? 0 : ey + 1);
      end
   end
   // main sequence
   initial
   begin
      void'($urandom(89));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      feedOn <= 1'b1;
      repeat (12) @(posedge clk);
      // fifo refuses once full while the link idles
      check("pixInReady", pixInReady, 1'b0);
      check("words taken", q.size(), FIFO_DEPTH);
      check("inReset", inReset, 1'b1);
      check("backlightEn", backlightEn, 1'b0);
      supplyGood <= 1'b1;
      for (n = 0; n < 100 && rgbpt_if_i.panelRstN !== 1'b1; n++)
         @(posedge clk);
      // a release that never comes must not pass as a long enough pulse
      if (n == 100)
      begin
         err_count++;
         summarize();
      end
      check("reset hold", n >= RH, 1'b1);
      check("backlightEn", backlightEn, 1'b0);
      @(posedge clk);
      check("backlightEn", backlightEn, 1'b1);
      // both framings, all flip pairs, dither only on plain scan order
      for (int f = 0; f < 9; f++)
      begin
         waitVs(1'b1);
         modeSel <= ~f[2];
         flipH <= f[0];
         flipV <= f[1];
         ditherOff <= !(f[0] && !f[1]);
         feedOn <= (f < 8);
         waitVs(1'b0);
      end
      waitVs(1'b1);
      check("underrun", underSeen, 1'b1);
      check("line length error", lenErrSeen, 1'b0);
      check("words left", q.size(), 0);
      check("inReset", inReset, 1'b0);
      summarize();
   end
endmodule : testbench
